//--- common/lrl_pkg.sv
package lrl_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] LRL_ADDR_STATUS      = 8'h07;
   localparam logic [7:0] LRL_ADDR_AMB_LOW     = 8'h0d;
   localparam logic [7:0] LRL_ADDR_AMB_MID     = 8'h0e;
   localparam logic [7:0] LRL_ADDR_AMB_HIGH    = 8'h0f;
   localparam logic [7:0] LRL_ADDR_UV_LOW      = 8'h10;
   localparam logic [7:0] LRL_ADDR_UV_MID      = 8'h11;
   localparam logic [7:0] LRL_ADDR_UV_HIGH     = 8'h12;
   localparam logic [7:0] LRL_ADDR_INT_CFG     = 8'h19;
   localparam logic [7:0] LRL_ADDR_PERSIST     = 8'h1a;
   localparam logic [7:0] LRL_ADDR_UP_LOW      = 8'h21;
   localparam logic [7:0] LRL_ADDR_UP_MID      = 8'h22;
   localparam logic [7:0] LRL_ADDR_UP_HIGH     = 8'h23;
   localparam logic [7:0] LRL_ADDR_LO_LOW      = 8'h24;
   localparam logic [7:0] LRL_ADDR_LO_MID      = 8'h25;
   localparam logic [7:0] LRL_ADDR_LO_HIGH     = 8'h26;
   // Frozen address window
   localparam logic [7:0] LRL_LOCK_FIRST       = 8'h07;
   localparam logic [7:0] LRL_LOCK_LAST        = 8'h12;

   // ------------------------------------------------------------
   // Field positions and codes
   // ------------------------------------------------------------
   localparam int         LRL_ST_POWER_ON_BIT  = 5;
   localparam int         LRL_ST_IRQ_BIT       = 4;
   localparam int         LRL_ST_NEW_DATA_BIT  = 3;
   localparam int         LRL_CFG_EN_BIT       = 2;
   localparam int         LRL_CFG_SEL_LSB      = 4;
   localparam logic [1:0] LRL_SEL_AMBIENT      = 2'h1;
   localparam logic [1:0] LRL_SEL_UV           = 2'h3;
   localparam logic [7:0] LRL_CFG_WR_MASK      = 8'h34;
   localparam int         LRL_PERSIST_LSB      = 4;
   localparam logic [7:0] LRL_PERSIST_WR_MASK  = 8'hf0;
   localparam logic [7:0] LRL_HIGH_NIBBLE_MASK = 8'h0f;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  LRL_CFG_RESET       = 8'h10;
   localparam logic [7:0]  LRL_PERSIST_RESET   = 8'h00;
   localparam logic [19:0] LRL_UP_RESET        = 20'hfffff;
   localparam logic [19:0] LRL_LO_RESET        = 20'h00000;
   localparam logic [19:0] LRL_RESULT_RESET    = 20'h00000;

   // ------------------------------------------------------------
   // Resolution codes and effective result masks
   // ------------------------------------------------------------
   localparam logic [19:0] LRL_MASK_20         = 20'hfffff;
   localparam logic [19:0] LRL_MASK_19         = 20'h7ffff;
   localparam logic [19:0] LRL_MASK_18         = 20'h3ffff;
   localparam logic [19:0] LRL_MASK_17         = 20'h1ffff;
   localparam logic [19:0] LRL_MASK_16         = 20'h0ffff;
   localparam logic [19:0] LRL_MASK_13         = 20'h01fff;
   localparam logic [2:0]  LRL_RES_20          = 3'h0;
   localparam logic [2:0]  LRL_RES_19          = 3'h1;
   localparam logic [2:0]  LRL_RES_18          = 3'h2;
   localparam logic [2:0]  LRL_RES_17          = 3'h3;
   localparam logic [2:0]  LRL_RES_16          = 3'h4;
   localparam logic [2:0]  LRL_RES_13          = 3'h5;
endpackage

//--- hdl/lrl_result_latch.sv
`timescale 1ns/1ps
// Functional notes
// - Ambient result unsigned, 13 to 20 bits
// - Ultraviolet result unsigned, 13 to 20 bits
// - Results frozen during reads of 0x07-0x12
// - Ambient shadow copied when no locked read
// - Ultraviolet shadow copied when no locked read
// - Ambient bytes at 0x0D, 0x0E, 0x0F
// - Ultraviolet bytes at 0x10, 0x11, 0x12
// - Interrupt enable bit 2 gates interrupts
// - Bits 5:4 select comparator channel
// - Comparator fed from visible selected result
// - Status bit 4 threshold flag, clear-on-read
// - Status bit 3 new data, clear-on-read
// - Persist N needs N+1 consecutive hits
// - 20-bit thresholds at 0x21 to 0x26
module lrl_result_latch (
   input  wire logic        clock,       // System clock, 10 MHz
   input  wire logic        rst_n,       // Synchronous reset, active low
   input  wire logic        clk_en,      // Freezes all state while low
   input  wire logic [7:0]  reg_addr,    // Register pointer from bus engine
   input  wire logic        reg_wr,      // Write strobe, one cycle
   input  wire logic [7:0]  reg_wdata,   // Write data
   input  wire logic        reg_rd,      // Read strobe, one cycle
   input  wire logic        read_active, // Host read transaction ongoing
   input  wire logic [2:0]  res_code,    // Selected resolution code
   input  wire logic        amb_done,    // Ambient conversion finished
   input  wire logic [19:0] amb_value,   // Ambient conversion value
   input  wire logic        uv_done,     // Ultraviolet conversion finished
   input  wire logic [19:0] uv_value,    // Ultraviolet conversion value
   output logic      [7:0]  reg_rdata,   // Read data, registered
   output logic             light_irq    // Interrupt level, active high
);
   import lrl_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [19:0] amb_shadow, next_amb_shadow;
   logic [19:0] uv_shadow,  next_uv_shadow;
   logic        amb_pend,   next_amb_pend;
   logic        uv_pend,    next_uv_pend;
   logic [19:0] amb_vis,    next_amb_vis;
   logic [19:0] uv_vis,     next_uv_vis;
   logic [7:0]  int_cfg,    next_int_cfg;
   logic [7:0]  persist,    next_persist;
   logic [19:0] up_thr,     next_up_thr;
   logic [19:0] lo_thr,     next_lo_thr;
   logic        st_pwr,     next_st_pwr;
   logic        st_irq,     next_st_irq;
   logic        st_new,     next_st_new;
   logic [3:0]  hit_cnt,    next_hit_cnt;
   logic [7:0]  next_rdata;
   logic [7:0]  status_word;
   logic [19:0] res_mask;
   logic        locked;
   logic        sel_upd;
   logic [19:0] sel_val;
   logic        out_range;
   logic        rd_status;

   // Effective width of a conversion
   always_comb begin
      case (res_code)
         LRL_RES_20: res_mask = LRL_MASK_20;
         LRL_RES_19: res_mask = LRL_MASK_19;
         LRL_RES_18: res_mask = LRL_MASK_18;
         LRL_RES_17: res_mask = LRL_MASK_17;
         LRL_RES_16: res_mask = LRL_MASK_16;
         LRL_RES_13: res_mask = LRL_MASK_13;
         default:    res_mask = LRL_MASK_20;
      endcase
   end

   // Lock while a read points into the window
   assign locked = read_active && (reg_addr >= LRL_LOCK_FIRST) && (reg_addr <= LRL_LOCK_LAST);

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_amb_shadow = amb_shadow;
      next_uv_shadow  = uv_shadow;
      next_amb_pend   = amb_pend;
      next_uv_pend    = uv_pend;
      next_amb_vis    = amb_vis;
      next_uv_vis     = uv_vis;
      next_int_cfg    = int_cfg;
      next_persist    = persist;
      next_up_thr     = up_thr;
      next_lo_thr     = lo_thr;
      next_st_pwr     = st_pwr;
      next_st_irq     = st_irq;
      next_st_new     = st_new;
      next_hit_cnt    = hit_cnt;
      next_rdata      = reg_rdata;
      sel_upd         = 1'b0;
      sel_val         = amb_vis;
      out_range       = 1'b0;
      rd_status       = reg_rd && (reg_addr == LRL_ADDR_STATUS);
      // Status word, reserved bits zero
      status_word                      = 8'h00;
      status_word[LRL_ST_POWER_ON_BIT] = st_pwr;
      status_word[LRL_ST_IRQ_BIT]      = st_irq;
      status_word[LRL_ST_NEW_DATA_BIT] = st_new;

      // Conversions land in the shadows
      if (amb_done) begin
         next_amb_shadow = amb_value & res_mask;
         next_amb_pend   = 1'b1;
      end
      if (uv_done) begin
         next_uv_shadow = uv_value & res_mask;
         next_uv_pend   = 1'b1;
      end

      // Register read mux, reserved bits zero
      if (reg_rd) begin
         case (reg_addr)
            LRL_ADDR_STATUS:   next_rdata = status_word;
            LRL_ADDR_AMB_LOW:  next_rdata = amb_vis[7:0];
            LRL_ADDR_AMB_MID:  next_rdata = amb_vis[15:8];
            LRL_ADDR_AMB_HIGH: next_rdata = {4'h0, amb_vis[19:16]};
            LRL_ADDR_UV_LOW:   next_rdata = uv_vis[7:0];
            LRL_ADDR_UV_MID:   next_rdata = uv_vis[15:8];
            LRL_ADDR_UV_HIGH:  next_rdata = {4'h0, uv_vis[19:16]};
            LRL_ADDR_INT_CFG:  next_rdata = int_cfg;
            LRL_ADDR_PERSIST:  next_rdata = persist;
            LRL_ADDR_UP_LOW:   next_rdata = up_thr[7:0];
            LRL_ADDR_UP_MID:   next_rdata = up_thr[15:8];
            LRL_ADDR_UP_HIGH:  next_rdata = {4'h0, up_thr[19:16]};
            LRL_ADDR_LO_LOW:   next_rdata = lo_thr[7:0];
            LRL_ADDR_LO_MID:   next_rdata = lo_thr[15:8];
            LRL_ADDR_LO_HIGH:  next_rdata = {4'h0, lo_thr[19:16]};
            default:           next_rdata = 8'h00;
         endcase
      end

      // Status read clears its flags
      if (rd_status) begin
         next_st_pwr = 1'b0;
         next_st_irq = 1'b0;
         next_st_new = 1'b0;
      end

      // Host writes; result registers are not writable
      if (reg_wr) begin
         case (reg_addr)
            LRL_ADDR_INT_CFG: next_int_cfg = reg_wdata & LRL_CFG_WR_MASK;
            LRL_ADDR_PERSIST: next_persist = reg_wdata & LRL_PERSIST_WR_MASK;
            LRL_ADDR_UP_LOW:  next_up_thr[7:0]   = reg_wdata;
            LRL_ADDR_UP_MID:  next_up_thr[15:8]  = reg_wdata;
            LRL_ADDR_UP_HIGH: next_up_thr[19:16] = reg_wdata[3:0];
            LRL_ADDR_LO_LOW:  next_lo_thr[7:0]   = reg_wdata;
            LRL_ADDR_LO_MID:  next_lo_thr[15:8]  = reg_wdata;
            LRL_ADDR_LO_HIGH: next_lo_thr[19:16] = reg_wdata[3:0];
            default: ;
         endcase
      end

      // Shadow to visible copy outside the lock
      if (!locked && amb_pend) begin
         next_amb_vis  = amb_shadow;
         next_amb_pend = amb_done;
         next_st_new   = 1'b1;
         if (int_cfg[LRL_CFG_SEL_LSB +: 2] == LRL_SEL_AMBIENT) begin
            sel_upd = 1'b1;
            sel_val = amb_shadow;
         end
      end
      if (!locked && uv_pend) begin
         next_uv_vis  = uv_shadow;
         next_uv_pend = uv_done;
         next_st_new  = 1'b1;
         if (int_cfg[LRL_CFG_SEL_LSB +: 2] == LRL_SEL_UV) begin
            sel_upd = 1'b1;
            sel_val = uv_shadow;
         end
      end

      // Threshold compare and persistence on each new selected result
      if (sel_upd) begin
         out_range = (sel_val > up_thr) || (sel_val < lo_thr);
         if (!out_range) begin
            next_hit_cnt = 4'h0;
         end else if (hit_cnt >= persist[LRL_PERSIST_LSB +: 4]) begin
            if (int_cfg[LRL_CFG_EN_BIT]) begin
               next_st_irq = 1'b1;
            end
         end else begin
            next_hit_cnt = hit_cnt + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         amb_shadow <= LRL_RESULT_RESET;
         uv_shadow  <= LRL_RESULT_RESET;
         amb_pend   <= 1'b0;
         uv_pend    <= 1'b0;
         amb_vis    <= LRL_RESULT_RESET;
         uv_vis     <= LRL_RESULT_RESET;
         int_cfg    <= LRL_CFG_RESET;
         persist    <= LRL_PERSIST_RESET;
         up_thr     <= LRL_UP_RESET;
         lo_thr     <= LRL_LO_RESET;
         st_pwr     <= 1'b1;
         st_irq     <= 1'b0;
         st_new     <= 1'b0;
         hit_cnt    <= 4'h0;
         reg_rdata  <= 8'h00;
      end else if (clk_en) begin
         amb_shadow <= next_amb_shadow;
         uv_shadow  <= next_uv_shadow;
         amb_pend   <= next_amb_pend;
         uv_pend    <= next_uv_pend;
         amb_vis    <= next_amb_vis;
         uv_vis     <= next_uv_vis;
         int_cfg    <= next_int_cfg;
         persist    <= next_persist;
         up_thr     <= next_up_thr;
         lo_thr     <= next_lo_thr;
         st_pwr     <= next_st_pwr;
         st_irq     <= next_st_irq;
         st_new     <= next_st_new;
         hit_cnt    <= next_hit_cnt;
         reg_rdata  <= next_rdata;
      end
   end

   // Interrupt level follows the status flag
   assign light_irq = st_irq;

endmodule // lrl_result_latch

//--- sim/lrl_result_latch_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Port checks of the result latch
// ---------------------------------------------
module lrl_checker (
   input wire logic        clock,       // Clock
   input wire logic        rst_n,       // Reset
   input wire logic        clk_en,      // Enable
   input wire logic [7:0]  reg_addr,    // Pointer
   input wire logic        reg_wr,      // Write
   input wire logic [7:0]  reg_wdata,   // Write data
   input wire logic        reg_rd,      // Read
   input wire logic        read_active, // Read on
   input wire logic [2:0]  res_code,    // Resolution
   input wire logic        amb_done,    // Ambient done
   input wire logic [19:0] amb_value,   // Ambient value
   input wire logic        uv_done,     // UV done
   input wire logic [19:0] uv_value,    // UV value
   input wire logic [7:0]  reg_rdata,   // Read data
   input wire logic        light_irq    // Interrupt
);
   logic cfg_en;      // Copy of enable bit
   logic next_cfg_en; // Next enable copy
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Track the enable bit
   always_comb begin
      next_cfg_en = cfg_en;
      if (clk_en && reg_wr && reg_addr == 8'h19) next_cfg_en = reg_wdata[2];
   end
   always_ff @(posedge clock) begin
      if (!rst_n) cfg_en <= 1'b0;
      else cfg_en <= next_cfg_en;
   end
   sequence rd_at(logic [7:0] a);
      clk_en && reg_rd && reg_addr == a;
   endsequence
   sequence locked_status;
      rd_at(8'h07) ##0 read_active;
   endsequence
   rdata_hold_a: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
      else $error("read data moved");
   unmapped_zero_a: assert property (rd_at(8'h00) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   amb_nibble_a: assert property (rd_at(8'h0f) |=> reg_rdata[7:4] == 4'h0)
      else $error("ambient high nibble");
   uv_nibble_a: assert property (rd_at(8'h12) |=> reg_rdata[7:4] == 4'h0)
      else $error("uv high nibble");
   cfg_reserved_a: assert property (rd_at(8'h19) |=> (reg_rdata & 8'hcb) == 8'h00)
      else $error("config reserved bits");
   irq_clear_a: assert property (locked_status |=> !light_irq)
      else $error("flag not cleared");
   irq_unlocked_a: assert property ($rose(light_irq) |-> !($past(read_active) && ($past(reg_addr) inside {[8'h07:8'h12]})))
      else $error("flag set while locked");
   irq_enable_a: assert property ($rose(light_irq) |-> $past(cfg_en))
      else $error("flag set while disabled");
endmodule // lrl_checker
bind lrl_result_latch lrl_checker lrl_checker_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .read_active(read_active),
   .res_code(res_code), .amb_done(amb_done), .amb_value(amb_value), .uv_done(uv_done), .uv_value(uv_value),
   .reg_rdata(reg_rdata), .light_irq(light_irq));

//--- sim/lrl_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Host controller model
// ---------------------------------------------
module lrl_host_model (
   input  wire logic       clock,      // Clock
   output logic      [7:0] reg_addr,   // Pointer
   output logic            reg_wr,     // Write
   output logic      [7:0] reg_wdata,  // Write data
   output logic            reg_rd,     // Read
   output logic            read_active // Read on
);
   logic [7:0] exp_q[$]; // Expected read data
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      read_active = 1'b0;
   end
   // One byte write
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      #10;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock);
      #10;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // One byte read, transaction left open
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clock);
      #10;
      reg_addr = a;
      reg_rd = 1'b1;
      read_active = 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      #10;
      reg_rd = 1'b0;
   endtask
   // Close the read transaction
   task automatic stop();
      @(posedge clock);
      #10;
      read_active = 1'b0;
   endtask
endmodule // lrl_host_model

//--- sim/lrl_result_latch_test.sv
`timescale 1ns/1ps
module lrl_result_latch_test;
   import lrl_pkg::*;
   logic        clock = 0, rst_n = 0, clk_en = 1, amb_done = 0, uv_done = 0, rd_d = 0;
   logic [2:0]  res_code = 3'h0;
   logic [19:0] amb_value = 20'h0, uv_value = 20'h0, v;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, b;
   logic        reg_wr, reg_rd, read_active, light_irq, hit;
   logic [15:0] lfsr = 16'haa2a;
   logic [7:0]  cfgs[5] = '{8'h10, 8'h14, 8'h34, 8'h04, 8'h24};
   logic [2:0]  codes[6] = '{LRL_RES_20, LRL_RES_19, LRL_RES_13, LRL_RES_17, LRL_RES_18, LRL_RES_16};
   logic [19:0] masks[6] = '{LRL_MASK_20, LRL_MASK_19, LRL_MASK_13, LRL_MASK_17, LRL_MASK_18, LRL_MASK_16};
   int          failures = 0, check_count = 0;
   always #50 clock = ~clock;
   lrl_host_model lrl_host_model_inst (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .read_active(read_active));
   lrl_result_latch lrl_result_latch_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .read_active(read_active), .res_code(res_code),
      .amb_done(amb_done), .amb_value(amb_value), .uv_done(uv_done), .uv_value(uv_value),
      .reg_rdata(reg_rdata), .light_irq(light_irq));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Next pseudo-random word
   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Read data monitor, oldest note first
   always @(negedge clock) begin
      if (rd_d) chk("reg_rdata", lrl_host_model_inst.exp_q.pop_front(), reg_rdata);
      rd_d = reg_rd;
   end
   task automatic conv(bit uv, logic [19:0] x);
      @(posedge clock);
      #10;
      amb_value = x;
      uv_value = x;
      amb_done = !uv;
      uv_done = uv;
      @(posedge clock);
      #10;
      amb_done = 0;
      uv_done = 0;
      amb_value = ~x;
      uv_value = ~x;
      repeat (2) @(posedge clock);
      #10;
   endtask
   task automatic rd3(logic [7:0] a, logic [19:0] x);
      lrl_host_model_inst.rd(a, x[7:0]);
      lrl_host_model_inst.rd(a + 8'h01, x[15:8]);
      lrl_host_model_inst.rd(a + 8'h02, {4'h0, x[19:16]});
      lrl_host_model_inst.stop();
   endtask
   initial begin
      #500000;
      failures++;
      give_verdict;
   end
   initial begin
      repeat (20) @(posedge clock);
      #10;
      rst_n = 1;
      lrl_host_model_inst.rd(8'h07, 8'h20);
      lrl_host_model_inst.rd(8'h07, 8'h00);
      lrl_host_model_inst.rd(8'h30, 8'h00);
      lrl_host_model_inst.rd(8'h00, 8'h00);
      lrl_host_model_inst.rd(8'h23, 8'h0f);
      lrl_host_model_inst.rd(8'h19, 8'h10);
      rd3(8'h0d, 20'h0);
      rd3(8'h10, 20'h0);
      $display("reset values done");
      // Byte mapping and resolution masks
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         v = {lfsr[3:0], lfsr};
         res_code = codes[i];
         conv(i[0], v);
         b = i[0] ? 8'h10 : 8'h0d;
         lrl_host_model_inst.wr(b, 8'hff);
         rd3(b, v & masks[i]);
      end
      $display("mapping done");
      // Freeze during a locked read, release on leaving the range
      res_code = 3'h0;
      for (int c = 0; c < 2; c++) begin
         b = c[0] ? 8'h10 : 8'h0d;
         conv(c[0], 20'h12345);
         lrl_host_model_inst.rd(b, 8'h45);
         conv(c[0], 20'habcde);
         lrl_host_model_inst.rd(b + 8'h01, 8'h23);
         lrl_host_model_inst.rd(b + 8'h02, 8'h01);
         lrl_host_model_inst.rd(8'h19, 8'h10);
         repeat (2) @(posedge clock);
         rd3(b, 20'habcde);
      end
      lrl_host_model_inst.rd(8'h07, 8'h08);
      lrl_host_model_inst.stop();
      $display("lock done");
      // Enable and source select codes
      lrl_host_model_inst.wr(8'h19, 8'hff);
      lrl_host_model_inst.rd(8'h19, 8'h34);
      lrl_host_model_inst.wr(8'h25, 8'h01);
      for (int i = 0; i < 5; i++) begin
         lrl_host_model_inst.wr(8'h19, cfgs[i]);
         for (int c = 0; c < 2; c++) begin
            hit = (i == 1 && c == 0) || (i == 2 && c == 1);
            conv(c[0], 20'h00010);
            chk("light_irq", {7'h0, hit}, {7'h0, light_irq});
            lrl_host_model_inst.rd(8'h07, {3'h0, hit, 4'h8});
            lrl_host_model_inst.stop();
            chk("light_irq", 8'h00, {7'h0, light_irq});
         end
      end
      $display("select done");
      // Persist count of fifteen needs sixteen hits
      lrl_host_model_inst.wr(8'h19, 8'h14);
      lrl_host_model_inst.wr(8'h1a, 8'hff);
      for (int k = 0; k < 16; k++) begin
         conv(1'b0, 20'h00020);
         chk("light_irq", {7'h0, k == 15}, {7'h0, light_irq});
      end
      lrl_host_model_inst.rd(8'h1a, 8'hf0);
      lrl_host_model_inst.stop();
      $display("persist done");
      // Low clock enable freezes the configuration
      clk_en = 0;
      lrl_host_model_inst.wr(8'h19, 8'h00);
      clk_en = 1;
      lrl_host_model_inst.rd(8'h19, 8'h14);
      lrl_host_model_inst.stop();
      $display("enable done");
      give_verdict;
   end
endmodule // lrl_result_latch_test
